// >>> verification/sia_chk_sva.sv
// Concurrent checks on the two-wire link and on the sensor's frame outputs.
// Assumes the bench instantiates it beside the link interface, one clock.
`timescale 1ns/1ps
module sia_chk (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        scl,
    input wire logic        sda_host_oe,
    input wire logic        sda_dev_oe,
    input wire logic        frame_start,
    input wire logic [39:0] applied_exposure,
    input wire logic [7:0]  applied_gain,
    input wire logic [7:0]  audio_setup,
    input wire logic        exposure_pending,
    input wire logic        autoload_pulse
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Device changes its sda pull only with scl low, never pulls against the host
    property p_one_driver; !(sda_host_oe && sda_dev_oe); endproperty
    a_one_driver: assert property (p_one_driver) else $error("both ends pull sda");
    property p_dev_scl_low; $changed(sda_dev_oe) |-> !scl; endproperty
    a_dev_scl_low: assert property (p_dev_scl_low) else $error("device moved sda with scl high");
    // Frame outputs move only one cycle after a frame start
    property p_exp_frame; $changed(applied_exposure) |-> $past(frame_start); endproperty
    a_exp_frame: assert property (p_exp_frame) else $error("exposure moved off frame");
    property p_gain_frame; $changed(applied_gain) |-> $past(frame_start); endproperty
    a_gain_frame: assert property (p_gain_frame) else $error("gain moved off frame");
    // With scl high no register write can land in the same cycle
    property p_flag_clear; frame_start && scl |=> !exposure_pending; endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("flag kept past frame");
    property p_flag_fall; $fell(exposure_pending) |-> $past(frame_start); endproperty
    a_flag_fall: assert property (p_flag_fall) else $error("flag fell off frame");
    property p_audio_unused; audio_setup[7:6] == 2'b00; endproperty
    a_audio_unused: assert property (p_audio_unused) else $error("audio top bits set");
    property p_autoload_once; autoload_pulse |=> !autoload_pulse; endproperty
    a_autoload_once: assert property (p_autoload_once) else $error("autoload pulse too long");
endmodule

// >>> verification/testbench.sv
// Bench: APB-driven bus master facing the sensor port over the link.
// Assumes the controller answers APB with one access cycle.
`timescale 1ns/1ps
module testbench;
    import sia_pkg::*;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, frame_start = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000, rd;
    wire logic [31:0] prdata;
    wire logic [39:0] applied_exposure;
    wire logic [7:0]  applied_gain, audio_setup;
    wire logic        pready, pslverr, exposure_pending, autoload_pulse;
    int          fail_count = 0, n_checks = 0, pulses = 0;
    sia_if bus ();
    sia_ctrl_host i_sia_ctrl_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .link(bus));
    sia_sensor_dev i_sia_sensor_dev (.pclk(pclk), .presetn(presetn), .link(bus), .frame_start(frame_start),
        .applied_exposure(applied_exposure), .applied_gain(applied_gain), .audio_setup(audio_setup),
        .exposure_pending(exposure_pending), .autoload_pulse(autoload_pulse));
    sia_chk i_sia_chk (.pclk(pclk), .presetn(presetn), .scl(bus.scl), .sda_host_oe(bus.sda_host_oe),
        .sda_dev_oe(bus.sda_dev_oe), .frame_start(frame_start), .applied_exposure(applied_exposure),
        .applied_gain(applied_gain), .audio_setup(audio_setup), .exposure_pending(exposure_pending),
        .autoload_pulse(autoload_pulse));
    always #25 pclk = ~pclk;
    // Autoload pulses counted for the toggle scenario
    always @(posedge pclk) if (autoload_pulse === 1'b1) pulses <= pulses + 1;
    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    // One APB transfer; request held until pready is sampled high at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 50);
        rd = prdata;
        {psel, penable} <= 2'b00;
        if (pready !== 1'b1) begin fail_count++; tally_and_finish(); end
    endtask
    // Byte command, bounded busy poll, then ack bit or read byte judged
    task automatic op(input logic [2:0] o, input logic [7:0] d, input logic [7:0] exp);
        int k;
        apb(1'b1, APB_CMD, {16'h0000, d, 5'h00, o});
        rd = 32'h00000001;
        for (k = 0; k < 500 && rd[STS_BUSY_BIT] !== 1'b0; k++) apb(1'b0, APB_STATUS, 32'h00000000);
        if (k == 500) begin fail_count++; tally_and_finish(); end
        if (o == OP_READ_ACK || o == OP_READ_NACK) chk(rd[15:8], exp);
        else if (o != OP_STOP) chk({7'h00, rd[STS_ACK_BIT]}, exp);
    endtask
    task automatic frame();
        @(posedge pclk);
        frame_start <= 1'b1;
        @(posedge pclk);
        frame_start <= 1'b0;
        repeat (2) @(posedge pclk);
    endtask
    task automatic s_audio();
        chk(audio_setup, 8'h09);
        op(OP_START_WRITE, 8'h30, 8'h00);
        op(OP_START_WRITE, 8'h20, 8'h01);
        op(OP_WRITE, 8'h79, 8'h01);
        op(OP_START_WRITE, 8'h21, 8'h01);
        op(OP_READ_NACK, 8'h00, 8'h09);
        op(OP_START_WRITE, 8'h20, 8'h01);
        op(OP_WRITE, 8'h79, 8'h01);
        op(OP_WRITE, 8'hF6, 8'h01);
        op(OP_STOP, 8'h00, 8'h00);
        chk(audio_setup, 8'h36);
        op(OP_START_WRITE, 8'h21, 8'h01);
        op(OP_READ_ACK, 8'h00, 8'h36);
        op(OP_READ_ACK, 8'h00, 8'h36);
        op(OP_READ_NACK, 8'h00, 8'h36);
    endtask
    task automatic s_autoload();
        op(OP_START_WRITE, 8'h20, 8'h01);
        op(OP_WRITE, 8'h6C, 8'h01);
        op(OP_WRITE, 8'h01, 8'h01);
        op(OP_WRITE, 8'h00, 8'h01);
        op(OP_STOP, 8'h00, 8'h00);
        chk(pulses, 1);
    endtask
    // Five exposure bytes and the gain by auto-increment; exposure applies at the next frame, gain one frame later
    task automatic s_exposure();
        op(OP_START_WRITE, 8'h20, 8'h01);
        op(OP_WRITE, 8'hA0, 8'h01);
        for (int i = 0; i < 6; i++) op(OP_WRITE, 8'(8'h11 * (i + 1)), 8'h01);
        op(OP_STOP, 8'h00, 8'h00);
        chk(exposure_pending, 1'b1);
        frame();
        chk(applied_exposure, 40'h1122334466);
        chk({exposure_pending, applied_gain}, 9'h000);
        frame();
        chk(applied_gain, 8'h55);
        op(OP_START_WRITE, 8'h20, 8'h01);
        op(OP_WRITE, 8'hA0, 8'h01);
        op(OP_START_WRITE, 8'h21, 8'h01);
        for (int i = 0; i < 5; i++) op(OP_READ_ACK, 8'h00, 8'(8'h11 * (i + 1)));
        op(OP_READ_NACK, 8'h00, 8'h66);
    endtask
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b1, APB_DIV, 32'h0000000C);
        s_audio();
        s_autoload();
        s_exposure();
        tally_and_finish();
    end
endmodule

// >>> verilog/sia_ctrl_host.sv
// Coprocessor end: two-wire bus master driven by byte commands over APB.
// Assumes an APB master on pclk; sda returns asynchronously from the link.
`timescale 1ns/1ps
module sia_ctrl_host (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output wire logic [31:0] prdata,
    output wire logic        pready,
    output wire logic        pslverr,
    sia_if.host              link
);
    import sia_pkg::*;

    typedef enum logic [8:0] {
        HS_IDLE   = 9'h001,
        HS_STA_A  = 9'h002,
        HS_STA_B  = 9'h004,
        HS_STA_C  = 9'h008,
        HS_BIT_LO = 9'h010,
        HS_BIT_HI = 9'h020,
        HS_STO_A  = 9'h040,
        HS_STO_B  = 9'h080,
        HS_STO_C  = 9'h100
    } sia_host_state_e;

    sia_host_state_e state_q, state_d;
    logic [2:0]      sda_s_q;
    logic            sda_f_q, sda_f_d;
    logic [15:0]     cnt_q, cnt_d, div_q, div_d;
    logic [3:0]      bit_q, bit_d;
    logic [8:0]      sh_q, sh_d;
    logic [7:0]      rx_q, rx_d;
    logic            ack_q, ack_d, scl_q, scl_d, oe_q, oe_d;
    logic [31:0]     prdata_q, prdata_d;
    logic            pready_q, pready_d, pslverr_q, pslverr_d;
    logic            busy, access, cmd_go, tick;
    logic [2:0]      opcode;
    logic [7:0]      cmd_data;

    assign busy     = (state_q != HS_IDLE);
    assign access   = psel & penable & pready_q;
    assign cmd_go   = access & pwrite & (paddr == APB_CMD) & ~busy;
    assign opcode   = pwdata[CMD_OP_LSB +: 3];
    assign cmd_data = pwdata[CMD_DATA_LSB +: 8];
    assign tick     = (cnt_q == 16'h0000);

    assign prdata           = prdata_q;
    assign pready           = pready_q;
    assign pslverr          = pslverr_q;
    assign link.scl         = scl_q;
    assign link.sda_host_o  = 1'b0;  // Open drain: only ever pulls low
    assign link.sda_host_oe = oe_q;

    // Next-state logic for APB slave and bit engine
    always_comb begin
        sda_f_d   = (sda_s_q[1] == sda_s_q[2]) ? sda_s_q[2] : sda_f_q;
        state_d   = state_q;
        cnt_d     = tick ? 16'h0000 : cnt_q - 16'h0001;
        div_d     = div_q;
        bit_d     = bit_q;
        sh_d      = sh_q;
        rx_d      = rx_q;
        ack_d     = ack_q;
        scl_d     = scl_q;
        oe_d      = oe_q;
        prdata_d  = prdata_q;
        // Answer in the first access cycle; one wait-free beat per transfer
        pready_d  = psel & ~pready_q;
        pslverr_d = 1'b0;
        if (pready_d) begin
            prdata_d = 32'h0000_0000;
            if (paddr == APB_STATUS) begin
                prdata_d[STS_BUSY_BIT]     = busy;
                prdata_d[STS_ACK_BIT]      = ack_q;
                prdata_d[STS_RX_LSB +: 8]  = rx_q;
            end else if (paddr == APB_DIV) begin
                prdata_d[15:0] = div_q;
            end else if (paddr == APB_CMD) begin
                pslverr_d = pwrite & busy;  // Busy engine refuses commands
            end else begin
                pslverr_d = 1'b1;
            end
        end
        if (access && pwrite && paddr == APB_DIV) begin
            div_d = pwdata[15:0];
        end
        case (state_q)
            HS_IDLE: begin
                // Between bytes sda belongs to the sensor; a held ack would clash with its data
                oe_d = 1'b0;
                if (cmd_go) begin
                    // Ack slot released on writes; driven low or left high on reads
                    sh_d  = (opcode == OP_START_WRITE || opcode == OP_WRITE) ? {cmd_data, 1'b1}
                          : {8'hFF, (opcode == OP_READ_NACK)};
                    bit_d = 4'h0;
                    if (opcode == OP_START_WRITE) begin
                        state_d = HS_STA_A;
                        scl_d   = 1'b0;
                        oe_d    = 1'b0;
                    end else if (opcode == OP_STOP) begin
                        state_d = HS_STO_A;
                        scl_d   = 1'b0;
                        oe_d    = 1'b1;
                    end else if (opcode == OP_WRITE || opcode == OP_READ_ACK || opcode == OP_READ_NACK) begin
                        state_d = HS_BIT_LO;
                        scl_d   = 1'b0;
                    end
                end
            end
            HS_STA_A: if (tick) begin
                state_d = HS_STA_B;
                scl_d   = 1'b1;
            end
            HS_STA_B: if (tick) begin
                state_d = HS_STA_C;
                oe_d    = 1'b1;  // Data falls while clock high
            end
            HS_STA_C: if (tick) begin
                state_d = HS_BIT_LO;
                scl_d   = 1'b0;
            end
            HS_BIT_LO: begin
                // A one is let go just after the fall, before the sensor can start its ack
                if (cnt_q == div_q - 16'h0001 && sh_q[8]) begin
                    oe_d = 1'b0;
                end
                // A zero is pulled mid-low so it never moves near a clock edge
                if (cnt_q == {1'b0, div_q[15:1]}) begin
                    oe_d = ~sh_q[8];
                end
                if (tick) begin
                    state_d = HS_BIT_HI;
                    scl_d   = 1'b1;
                end
            end
            HS_BIT_HI: if (tick) begin
                scl_d = 1'b0;
                sh_d  = {sh_q[7:0], 1'b1};
                bit_d = bit_q + 4'h1;
                if (bit_q == BITS_PER_BYTE) begin
                    ack_d   = ~sda_f_q;
                    state_d = HS_IDLE;
                end else begin
                    rx_d    = {rx_q[6:0], sda_f_q};
                    state_d = HS_BIT_LO;
                end
            end
            HS_STO_A: if (tick) begin
                state_d = HS_STO_B;
                scl_d   = 1'b1;
            end
            HS_STO_B: if (tick) begin
                state_d = HS_STO_C;
                oe_d    = 1'b0;  // Data rises while clock high
            end
            HS_STO_C: if (tick) begin
                state_d = HS_IDLE;
            end
            default: begin
                state_d = HS_IDLE;
            end
        endcase
        // Every new phase lasts one half period
        if (state_d != state_q) begin
            cnt_d = div_q - 16'h0001;
        end
    end

    // State registers; three-stage synchroniser on the returning data line
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sda_s_q   <= 3'h7;
            sda_f_q   <= 1'b1;
            state_q   <= HS_IDLE;
            cnt_q     <= 16'h0000;
            div_q     <= SCL_HALF_CYC;
            bit_q     <= 4'h0;
            sh_q      <= 9'h1FF;
            rx_q      <= 8'h00;
            ack_q     <= 1'b0;
            scl_q     <= 1'b1;
            oe_q      <= 1'b0;
            prdata_q  <= 32'h0000_0000;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            sda_s_q   <= {sda_s_q[1:0], link.sda};
            sda_f_q   <= sda_f_d;
            state_q   <= state_d;
            cnt_q     <= cnt_d;
            div_q     <= div_d;
            bit_q     <= bit_d;
            sh_q      <= sh_d;
            rx_q      <= rx_d;
            ack_q     <= ack_d;
            scl_q     <= scl_d;
            oe_q      <= oe_d;
            prdata_q  <= prdata_d;
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end
endmodule

// >>> verilog/sia_if.sv
// Two-wire link between the coprocessor controller and the sensor port.
// Data line is open drain; the wire level is resolved here from the enables.
`timescale 1ns/1ps
interface sia_if;
    logic scl;
    logic sda;
    logic sda_host_o;
    logic sda_host_oe;
    logic sda_dev_o;
    logic sda_dev_oe;

    // Wired-AND with pull-up
    assign sda = (sda_host_oe ? sda_host_o : 1'b1) & (sda_dev_oe ? sda_dev_o : 1'b1);

    modport dev  (input scl, input sda, output sda_dev_o, output sda_dev_oe);
    modport host (output scl, input sda, output sda_host_o, output sda_host_oe);
endinterface

// >>> verilog/sia_pkg.sv
// Constants shared by both ends of the sensor two-wire register link.
// Assumes a 20 MHz pclk on both ends.
package sia_pkg;
    // Link addressing and register indices
    localparam logic [6:0] SLAVE_ADDR      = 7'h10;  // 0x20 write, 0x21 read
    localparam logic [6:0] IDX_STATUS      = 7'h00;
    localparam logic [6:0] IDX_FINE_HI     = 7'h20;
    localparam logic [6:0] IDX_FINE_LO     = 7'h21;
    localparam logic [6:0] IDX_COARSE_HI   = 7'h22;
    localparam logic [6:0] IDX_COARSE_LO   = 7'h23;
    localparam logic [6:0] IDX_GAIN        = 7'h24;
    localparam logic [6:0] IDX_CLK_DIV     = 7'h25;
    localparam logic [6:0] IDX_FRAME_SETUP = 7'h6C;
    localparam logic [6:0] IDX_AUDIO       = 7'h79;
    localparam logic [6:0] IDX_RESERVED    = 7'h7A;  // 0x7A..0x7F ignore writes
    localparam int         NUM_REGS        = 128;
    localparam int         DW              = 8;
    // Field positions and reset values
    localparam int         FS_AUTOLOAD_BIT = 0;
    localparam int         ST_EXP_FLAG_BIT = 0;
    localparam int         AUD_GAIN1_BIT   = 0;
    localparam int         AUD_GAIN2_LSB   = 1;
    localparam int         AUD_PDOWN_BIT   = 3;
    localparam int         AUD_DIFF_BIT    = 4;
    localparam int         AUD_BOOST_BIT   = 5;
    localparam logic [7:0] AUDIO_RESET     = 8'h09;
    localparam logic [7:0] AUDIO_MASK      = 8'h3F;
    localparam logic [3:0] BITS_PER_BYTE   = 4'h8;
    // Controller APB map
    localparam logic [7:0] APB_CMD         = 8'h00;
    localparam logic [7:0] APB_STATUS      = 8'h04;
    localparam logic [7:0] APB_DIV         = 8'h08;
    localparam int         CMD_OP_LSB      = 0;
    localparam int         CMD_DATA_LSB    = 8;
    localparam logic [2:0] OP_START_WRITE  = 3'h1;
    localparam logic [2:0] OP_WRITE        = 3'h2;
    localparam logic [2:0] OP_READ_ACK     = 3'h3;
    localparam logic [2:0] OP_READ_NACK    = 3'h4;
    localparam logic [2:0] OP_STOP         = 3'h5;
    localparam int         STS_BUSY_BIT    = 0;
    localparam int         STS_ACK_BIT     = 1;
    localparam int         STS_RX_LSB      = 8;
    // Timing: half period of the link clock
    localparam int         PCLK_NS         = 50;
    localparam int         SCL_HALF_NS     = 5000;
    localparam logic [15:0] SCL_HALF_CYC   = 16'((SCL_HALF_NS + PCLK_NS - 1) / PCLK_NS);
endpackage

// >>> verilog/sia_sensor_dev.sv
// Sensor end of the two-wire register link: slave port, register array,
// exposure shadowing per frame and audio amplifier setup.
// Assumes frame_start is a one-cycle pulse on pclk; scl and sda are asynchronous.
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
module sia_sensor_dev (
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    sia_if.dev                              link,
    input  wire logic                       frame_start,
    output wire logic [5*sia_pkg::DW-1:0]   applied_exposure,
    output wire logic [sia_pkg::DW-1:0]     applied_gain,
    output wire logic [sia_pkg::DW-1:0]     audio_setup,
    output wire logic                       exposure_pending,
    output wire logic                       autoload_pulse
);
    import sia_pkg::*;

    typedef enum logic [7:0] {
        DS_IDLE     = 8'h01,
        DS_ADDR     = 8'h02,
        DS_ADDR_ACK = 8'h04,
        DS_RX       = 8'h08,
        DS_RX_ACK   = 8'h10,
        DS_TX       = 8'h20,
        DS_TX_ACK   = 8'h40,
        DS_TX_NEXT  = 8'h80
    } sia_dev_state_e;

    sia_dev_state_e      state_q, state_d;
    logic [2:0]          scl_s_q, sda_s_q;
    logic                scl_f_q, scl_f_d, sda_f_q, sda_f_d;
    logic [3:0]          cnt_q, cnt_d;
    logic [7:0]          rx_q, rx_d, tx_q, tx_d;
    logic                oe_q, oe_d, rw_q, rw_d, first_q, first_d, inc_q, inc_d;
    logic [6:0]          idx_q, idx_d;
    logic [DW-1:0]       regs_q [0:NUM_REGS-1];
    logic [DW-1:0]       regs_d [0:NUM_REGS-1];
    logic                flag_q, flag_d, autoload_q, autoload_d;
    logic [5*DW-1:0]     applied_q, applied_d;
    logic [DW-1:0]       pend_gain_q, pend_gain_d, gain_q, gain_d;
    logic                scl_rise, scl_fall, start_cond, stop_cond;
    logic [7:0]          rd_val;

    // Bus conditions from the filtered lines; scl must stay high for start/stop
    assign scl_rise   = scl_f_d & ~scl_f_q;
    assign scl_fall   = ~scl_f_d & scl_f_q;
    assign start_cond = ~sda_f_d & sda_f_q & scl_f_d & scl_f_q;
    assign stop_cond  = sda_f_d & ~sda_f_q & scl_f_d & scl_f_q;
    // Status location shows the live flag, everything else the array
    assign rd_val = (idx_q == IDX_STATUS) ? {7'h00, flag_q} : regs_q[idx_q];

    assign link.sda_dev_o   = 1'b0;  // Open drain: only ever pulls low
    assign link.sda_dev_oe  = oe_q;
    assign applied_exposure = applied_q;
    assign applied_gain     = gain_q;
    assign audio_setup      = regs_q[IDX_AUDIO];
    assign exposure_pending = flag_q;
    assign autoload_pulse   = autoload_q;

    // Next-state logic for filter, slave engine and register effects
    always_comb begin
        scl_f_d    = (scl_s_q[1] == scl_s_q[2]) ? scl_s_q[2] : scl_f_q;
        sda_f_d    = (sda_s_q[1] == sda_s_q[2]) ? sda_s_q[2] : sda_f_q;
        state_d    = state_q;
        cnt_d      = cnt_q;
        rx_d       = rx_q;
        tx_d       = tx_q;
        oe_d       = oe_q;
        rw_d       = rw_q;
        first_d    = first_q;
        idx_d      = idx_q;
        inc_d      = inc_q;
        regs_d     = regs_q;
        flag_d     = flag_q;
        autoload_d = 1'b0;
        applied_d  = applied_q;
        pend_gain_d = pend_gain_q;
        gain_d     = gain_q;
        // Frame boundary: shadowed values move one stage on
        if (frame_start) begin
            applied_d = {regs_q[IDX_FINE_HI], regs_q[IDX_FINE_LO], regs_q[IDX_COARSE_HI],
                         regs_q[IDX_COARSE_LO], regs_q[IDX_CLK_DIV]};
            pend_gain_d = regs_q[IDX_GAIN];
            gain_d      = pend_gain_q;
            flag_d      = 1'b0;
        end
        if (start_cond) begin
            // Repeated start is legal in any state
            state_d = DS_ADDR;
            cnt_d   = 4'h0;
            oe_d    = 1'b0;
        end else if (stop_cond) begin
            state_d = DS_IDLE;
            oe_d    = 1'b0;
        end else begin
            case (state_q)
                DS_ADDR, DS_RX: begin
                    if (scl_rise) begin
                        rx_d  = {rx_q[6:0], sda_f_d};
                        cnt_d = cnt_q + 4'h1;
                    end else if (scl_fall && cnt_q == BITS_PER_BYTE) begin
                        if (state_q == DS_ADDR) begin
                            if (rx_q[7:1] == SLAVE_ADDR) begin
                                oe_d    = 1'b1;
                                rw_d    = rx_q[0];
                                state_d = DS_ADDR_ACK;
                            end else begin
                                state_d = DS_IDLE;
                            end
                        end else begin
                            oe_d    = 1'b1;
                            state_d = DS_RX_ACK;
                            if (first_q) begin
                                idx_d = rx_q[6:0];
                                inc_d = rx_q[7];
                            end else begin
                                // Reserved and status locations drop writes; unused locations still store
                                if (idx_q < IDX_RESERVED && idx_q != IDX_STATUS) begin
                                    regs_d[idx_q] = (idx_q == IDX_AUDIO) ? (rx_q & AUDIO_MASK) : rx_q;
                                end
                                // Set wins over a same-cycle frame clear
                                if (idx_q >= IDX_FINE_HI && idx_q <= IDX_CLK_DIV) begin
                                    flag_d = 1'b1;
                                end
                                if (idx_q == IDX_FRAME_SETUP && regs_q[idx_q][FS_AUTOLOAD_BIT]
                                    && !rx_q[FS_AUTOLOAD_BIT]) begin
                                    autoload_d = 1'b1;
                                end
                                if (inc_q) begin
                                    idx_d = idx_q + 7'h01;
                                end // Else same register again
                            end
                        end
                    end
                end
                DS_ADDR_ACK: begin
                    if (scl_fall) begin
                        cnt_d = 4'h0;
                        if (rw_q) begin
                            tx_d    = rd_val;
                            oe_d    = ~rd_val[7];
                            state_d = DS_TX;
                        end else begin
                            oe_d    = 1'b0;
                            first_d = 1'b1;
                            state_d = DS_RX;
                        end
                    end
                end
                DS_RX_ACK: begin
                    if (scl_fall) begin
                        oe_d    = 1'b0;
                        cnt_d   = 4'h0;
                        first_d = 1'b0;
                        state_d = DS_RX;
                    end
                end
                DS_TX: begin
                    if (scl_fall) begin
                        if (cnt_q == BITS_PER_BYTE - 4'h1) begin
                            oe_d    = 1'b0;
                            state_d = DS_TX_ACK;
                        end else begin
                            tx_d  = {tx_q[6:0], 1'b0};
                            oe_d  = ~tx_q[6];
                            cnt_d = cnt_q + 4'h1;
                        end
                    end
                end
                DS_TX_ACK: begin
                    if (scl_rise) begin
                        if (inc_q) begin
                            idx_d = idx_q + 7'h01;
                        end // Else the same value is sent again
                        // Released line at the ack slot means the master is done
                        state_d = sda_f_d ? DS_IDLE : DS_TX_NEXT;
                    end
                end
                DS_TX_NEXT: begin
                    if (scl_fall) begin
                        tx_d    = rd_val;
                        oe_d    = ~rd_val[7];
                        cnt_d   = 4'h0;
                        state_d = DS_TX;
                    end
                end
                default: begin
                    oe_d = 1'b0;
                end
            endcase
        end
    end

    // State registers; three-stage synchronisers on both lines
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scl_s_q     <= 3'h7;
            sda_s_q     <= 3'h7;
            scl_f_q     <= 1'b1;
            sda_f_q     <= 1'b1;
            state_q     <= DS_IDLE;
            cnt_q       <= 4'h0;
            rx_q        <= 8'h00;
            tx_q        <= 8'h00;
            oe_q        <= 1'b0;
            rw_q        <= 1'b0;
            first_q     <= 1'b0;
            idx_q       <= 7'h00;
            inc_q       <= 1'b0;
            flag_q      <= 1'b0;
            autoload_q  <= 1'b0;
            applied_q   <= '0;
            pend_gain_q <= 8'h00;
            gain_q      <= 8'h00;
            for (int i = 0; i < NUM_REGS; i++) begin
                regs_q[i] <= (i == int'(IDX_AUDIO)) ? AUDIO_RESET : 8'h00;
            end
        end else begin
            scl_s_q     <= {scl_s_q[1:0], link.scl};
            sda_s_q     <= {sda_s_q[1:0], link.sda};
            scl_f_q     <= scl_f_d;
            sda_f_q     <= sda_f_d;
            state_q     <= state_d;
            cnt_q       <= cnt_d;
            rx_q        <= rx_d;
            tx_q        <= tx_d;
            oe_q        <= oe_d;
            rw_q        <= rw_d;
            first_q     <= first_d;
            idx_q       <= idx_d;
            inc_q       <= inc_d;
            flag_q      <= flag_d;
            autoload_q  <= autoload_d;
            applied_q   <= applied_d;
            pend_gain_q <= pend_gain_d;
            gain_q      <= gain_d;
            regs_q      <= regs_d;
        end
    end
endmodule
